// *** verif/aux_tx_user_model.sv ***
// aux_tx_user_model: user logic that drives the transmit mask
// assumes: status bus and mask share the core clock
`timescale 1ns/1ps
module aux_tx_user_model
  import aux_tx_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              bad_in,
  input  wire logic [STAT_W-1:0] status_in,
  output logic      [31:0]       mask_out
);
  tx_status_t st;

  assign st = tx_status_t'(status_in);

  // word paced by the index on the bus
  // mask quiet near comma
  // frames 255 and 0 are kept clear, so the two-cycle lag of bus and mask flop cannot reach the slot
  always @(posedge ref_clk_in) begin
    if (bad_in) begin
      mask_out <= 32'h8000_0000;
    end else if (st.x != 8'h00 && st.x != 8'hFF) begin
      mask_out <= 32'hA5A5_0000 | {26'h0, st.seq};
    end else begin
      mask_out <= 32'h0000_0000;
    end
  end
endmodule

// *** verif/test_aux_tx_frame_status.sv ***
// test_aux_tx_frame_status: self-checking bench for the transmit status block
// assumes: 20 MHz core clock, axi4-lite settings, user model on the mask
`timescale 1ns/1ps
module test_aux_tx_frame_status;
  import aux_tx_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  logic              ref_clk_in = 1'b0;
  logic              reset_in   = 1'b1;
  logic [31:0]       mask;
  logic              bad        = 1'b0;
  logic [7:0]        awaddr     = 8'h00;
  logic              awvalid    = 1'b0;
  logic              awready;
  logic [31:0]       wdata      = 32'h0;
  logic              wvalid     = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready     = 1'b0;
  logic [7:0]        araddr     = 8'h00;
  logic              arvalid    = 1'b0;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready     = 1'b0;
  logic [STAT_W-1:0] status_out;
  tx_status_t        st;
  int                fails      = 0;
  int                tests_run  = 0;
  int                bad_steps;
  int                n_err;
  int                bad_err;
  logic [5:0]        max_seq;
  logic [5:0]        max_k;
  logic [5:0]        lasts [5]  = '{6'h07, 6'h0F, 6'h13, 6'h1F, 6'h27};

  assign st = tx_status_t'(status_out);
  always #25 ref_clk_in = ~ref_clk_in;

  aux_tx_frame_status #(.MASK_W(32)) u_dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .tx_mask_in(mask),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(4'hF), .wvalid_in(wvalid), .wready_out(wready),
    .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
    .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
    .rready_in(rready), .status_out(status_out)
  );

  aux_tx_user_model u_user (
    .ref_clk_in(ref_clk_in), .bad_in(bad), .status_in(status_out), .mask_out(mask)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic give_up();
    fails++;
    $display("ERROR t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    test_done();
  endtask

  // handshakes are judged at the falling edge, so design flops never race the bench
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta;
    logic tw;
    logic tb;
    logic [1:0] got;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge ref_clk_in);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      got = bresp;
      @(posedge ref_clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        check(got, RESP_OKAY);
        return;
      end
    end
    give_up();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    logic ta;
    logic tr;
    logic [31:0] got;
    logic [1:0] gr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge ref_clk_in);
      ta = arvalid && arready;
      tr = rvalid && rready;
      got = rdata;
      gr = rresp;
      @(posedge ref_clk_in);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        check(got, d);
        check(gr, rsp);
        return;
      end
    end
    give_up();
  endtask

  task automatic wait_bit(input int b, output int c);
    for (c = 0; c < 3000; c++) begin
      @(negedge ref_clk_in);
      if (status_out[b] === 1'b1) return;
    end
    give_up();
  endtask

  // gathers step faults, peaks and error pulses over n cycles
  task automatic watch(input int n, input logic [5:0] last);
    tx_status_t p;
    int i;
    bad_steps = 0;
    max_seq = 6'h00;
    max_k = 6'h00;
    n_err = 0;
    bad_err = 0;
    @(negedge ref_clk_in);
    p = st;
    for (i = 0; i < n; i++) begin
      @(negedge ref_clk_in);
      if (st.seq > max_seq) max_seq = st.seq;
      if (st.k > max_k) max_k = st.k;
      if (st.error === 1'b1) begin
        n_err++;
        if (p.seq !== 6'h00 || p.x !== 8'h00) bad_err++;
      end
      if (p.seq == last) begin
        if (st.seq !== 6'h00 || st.x !== p.x + 8'h01) bad_steps++;
      end else if (st.seq !== p.seq + 6'h01 || st.x !== p.x) begin
        bad_steps++;
      end
      p = st;
    end
    @(posedge ref_clk_in);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd(CTRL_ADDR, CTRL_RESET, RESP_OKAY);
    rd(OFFSET_ADDR, OFFS_RESET, RESP_OKAY);
    rd(KCFG_ADDR, {26'h0, KMAX_RESET}, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    $display("t_regs done");
  endtask

  task automatic t_rates();
    int r;
    for (r = 0; r < 5; r++) begin
      wr(CTRL_ADDR, 32'h0000_1000 | r);
      watch(120, lasts[r]);
      check(bad_steps, 0);
      check(max_seq, lasts[r]);
    end
    $display("t_rates done");
  endtask

  task automatic t_kcount();
    wr(KCFG_ADDR, 32'h0000_0003);
    wr(CTRL_ADDR, 32'h0000_1010);
    watch(200, 6'h07);
    check(max_k, 6'h03);
    wr(CTRL_ADDR, 32'h0000_1000);
    watch(50, 6'h07);
    check(max_k, 6'h00);
    $display("t_kcount done");
  endtask

  task automatic t_hyper();
    int c;
    logic [7:0] h0;
    wait_bit(HFP_BIT, c);
    h0 = st.hfn;
    check({st.seq, st.x}, 14'h0);
    @(negedge ref_clk_in);
    check(st.hfp, 1'b0);
    wait_bit(HFP_BIT, c);
    check(c + 2, 8 * 256);
    check(st.hfn, (h0 == 8'h95) ? 8'h00 : h0 + 8'h01);
    @(posedge ref_clk_in);
    $display("t_hyper done");
  endtask

  task automatic t_start();
    int c;
    int d;
    wr(OFFSET_ADDR, 32'h0000_0005);
    wr(CTRL_ADDR, 32'h0000_1100);
    wait_bit(HFP_BIT, c);
    wait_bit(START_BIT, c);
    check(c >= 4 && c <= 20, 1'b1);
    check(st.seq, 6'h00);
    for (d = 0; d < 40 && st.start === 1'b1; d++) @(negedge ref_clk_in);
    check(d, 8);
    @(posedge ref_clk_in);
    $display("t_start done");
  endtask

  task automatic t_error();
    bad <= 1'b0;
    watch(2100, 6'h07);
    check(n_err, 0);
    bad <= 1'b1;
    watch(2100, 6'h07);
    bad <= 1'b0;
    check(n_err > 0, 1'b1);
    check(bad_err, 0);
    $display("t_error done");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check(status_out[43:12], 32'h0);
    check(status_out[11:0], 12'h0);
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    t_regs();
    t_rates();
    t_kcount();
    t_hyper();
    t_start();
    t_error();
    test_done();
  end
endmodule

// *** verilog/aux_tx_frame_status.sv ***
// aux_tx_frame_status: transmit frame timing status for the aux interface
// assumes: single core clock, mask from user logic on that clock
`timescale 1ns/1ps

module aux_tx_frame_status
  import aux_tx_pkg::*;
#(
  parameter int MASK_W = 32
) (
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  input  wire logic [MASK_W-1:0] tx_mask_in,
  input  wire logic [7:0]        awaddr_in,
  input  wire logic              awvalid_in,
  output logic                   awready_out,
  input  wire logic [31:0]       wdata_in,
  input  wire logic [3:0]        wstrb_in,
  input  wire logic              wvalid_in,
  output logic                   wready_out,
  output logic [1:0]             bresp_out,
  output logic                   bvalid_out,
  input  wire logic              bready_in,
  input  wire logic [7:0]        araddr_in,
  input  wire logic              arvalid_in,
  output logic                   arready_out,
  output logic [31:0]            rdata_out,
  output logic [1:0]             rresp_out,
  output logic                   rvalid_out,
  input  wire logic              rready_in,
  output logic [STAT_W-1:0]      status_out
);

  initial begin
    if (MASK_W != 32) $error("mask width must be 32");
  end

  tx_cfg_t     cfg;
  tx_status_t  st;
  logic [5:0]  seq_reg;
  logic [5:0]  k_reg;
  logic [7:0]  x_reg;
  logic [7:0]  hfn_reg;
  logic [11:0] bfn_reg;
  logic        hfp_reg;
  logic        rfp_reg;
  logic        start_reg;
  logic        err;
  logic        seq_wrap;
  logic        x_wrap;
  logic        hfn_wrap;
  logic        bf_start;
  logic        comma_slot;
  logic [5:0]  seq_last_cur;
  logic [19:0] off_cnt_reg;
  logic        start_pulse;
  logic [5:0]  start_len_reg;

  typedef enum logic [1:0] {
    ST_IDLE, ST_COUNT, ST_WAIT_BF, ST_HIGH
  } start_state_t;
  start_state_t start_state_reg;

  // ****************************************
  // register slave
  // ****************************************
  aux_tx_regs u_regs (
    .ref_clk_in  (ref_clk_in),
    .reset_in    (reset_in),
    .awaddr_in   (awaddr_in),
    .awvalid_in  (awvalid_in),
    .awready_out (awready_out),
    .wdata_in    (wdata_in),
    .wstrb_in    (wstrb_in),
    .wvalid_in   (wvalid_in),
    .wready_out  (wready_out),
    .bresp_out   (bresp_out),
    .bvalid_out  (bvalid_out),
    .bready_in   (bready_in),
    .araddr_in   (araddr_in),
    .arvalid_in  (arvalid_in),
    .arready_out (arready_out),
    .rdata_out   (rdata_out),
    .rresp_out   (rresp_out),
    .rvalid_out  (rvalid_out),
    .rready_in   (rready_in),
    .status_in   (st),
    .cfg_out     (cfg)
  );

  // ****************************************
  // frame counters
  // ****************************************
  assign seq_last_cur = seq_last(cfg.rate);
  assign seq_wrap  = (seq_reg >= seq_last_cur);
  assign x_wrap    = seq_wrap && (x_reg == X_LAST);
  assign hfn_wrap  = x_wrap && (hfn_reg == HFN_LAST);
  assign bf_start  = seq_wrap;
  // comma slot decode
  // index leads the wire by two cycles, so the slot is where index sits at 0
  assign comma_slot = (seq_reg == 6'h00) && (x_reg == 8'h00) && (hfn_reg == 8'h00)
                      && !hfp_reg ? 1'b0 : (seq_reg == 6'h00) && (x_reg == 8'h00);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      seq_reg <= 6'h00;
    end else if (seq_wrap) begin
      seq_reg <= 6'h00;
    end else begin
      seq_reg <= seq_reg + 6'h01;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      x_reg <= 8'h00;
    end else if (seq_wrap) begin
      x_reg <= x_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      hfn_reg <= 8'h00;
    end else if (x_wrap) begin
      hfn_reg <= (hfn_reg == HFN_LAST) ? 8'h00 : hfn_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bfn_reg <= 12'h000;
    end else if (hfn_wrap) begin
      bfn_reg <= bfn_reg + 12'h001;
    end
  end

  // sample counter
  // frozen at zero in mode 00 since nothing consumes it there
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      k_reg <= 6'h00;
    end else if (cfg.map_mode == MAP_NONE || cfg.map_mode == MAP_RSVD) begin
      k_reg <= 6'h00;
    end else if (seq_wrap) begin
      k_reg <= (k_reg >= cfg.k_last || x_wrap) ? 6'h00 : k_reg + 6'h01;
    end
  end

  // ****************************************
  // frame pulses
  // ****************************************
  // hyperframe and radio frame pulses
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      hfp_reg <= 1'b0;
      rfp_reg <= 1'b0;
    end else begin
      hfp_reg <= x_wrap;
      rfp_reg <= hfn_wrap;
    end
  end

  // ****************************************
  // start indication
  // ****************************************
  // offset count from chosen pulse
  assign start_pulse = cfg.sel_hfp ? hfp_reg : rfp_reg;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      start_state_reg <= ST_IDLE;
      off_cnt_reg     <= 20'h00000;
      start_reg       <= 1'b0;
    end else begin
      case (start_state_reg)
        ST_IDLE: begin
          start_reg <= 1'b0;
          if (cfg.enable && start_pulse) begin
            off_cnt_reg     <= cfg.offset;
            start_state_reg <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (off_cnt_reg == 20'h00000) begin
            start_state_reg <= ST_WAIT_BF;
          end else begin
            off_cnt_reg <= off_cnt_reg - 20'h00001;
          end
        end
        ST_WAIT_BF: begin
          if (bf_start) begin
            start_reg       <= 1'b1;
            start_state_reg <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (bf_start) begin
            start_reg       <= 1'b0;
            start_state_reg <= ST_IDLE;
          end
        end
        default: begin
          start_reg       <= 1'b0;
          start_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // error check and status bus
  // ****************************************
  aux_tx_mask_check #(
    .MASK_W (MASK_W)
  ) u_mask (
    .ref_clk_in    (ref_clk_in),
    .reset_in      (reset_in),
    .mask_in       (tx_mask_in),
    .comma_slot_in (comma_slot),
    .error_out     (err)
  );

  always_comb begin
    st.error = err;
    st.seq   = seq_reg;
    st.k     = k_reg;
    st.x     = x_reg;
    st.hfn   = hfn_reg;
    st.bfn   = bfn_reg;
    st.hfp   = hfp_reg;
    st.start = start_reg;
    st.rfp   = rfp_reg;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      status_out <= '0;
    end else begin
      status_out <= st;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence bf_edge_s;
    seq_wrap ##1 1'b1;
  endsequence

  // cycles spent high
  // helper count, a long repetition would choke the property engines
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      start_len_reg <= 6'h00;
    end else if (start_reg) begin
      start_len_reg <= start_len_reg + 6'h01;
    end else begin
      start_len_reg <= 6'h00;
    end
  end

  // a rate change lets the index sit past the new limit for one cycle
  seq_range_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $stable(cfg.rate) |-> seq_reg <= seq_last_cur)
    else $error("word index beyond rate limit");

  seq_wrap_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (seq_wrap && $stable(cfg.rate)) |=> seq_reg == 6'h00)
    else $error("word index failed to wrap");

  x_step_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    bf_edge_s |-> x_reg == $past(x_reg) + 8'h01)
    else $error("basic frame index did not advance");

  hfn_range_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    status_out[HFN_LSB +: 8] <= HFN_LAST)
    else $error("hyperframe number out of range");

  hfp_cause_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    x_wrap |=> hfp_reg ##1 !hfp_reg)
    else $error("hyperframe pulse wrong");

  rfp_cause_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    hfn_wrap |=> rfp_reg && bfn_reg == $past(bfn_reg) + 12'h001)
    else $error("radio frame pulse or number wrong");

  k_idle_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (cfg.map_mode == MAP_NONE) |=> k_reg == 6'h00)
    else $error("sample counter moved in mode 00");

  start_len_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $fell(start_reg) |-> start_len_reg == seq_last_cur + 6'h01)
    else $error("start indication not one basic frame long");

  start_src_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (start_state_reg == ST_IDLE && cfg.enable && start_pulse) |=>
      start_state_reg == ST_COUNT && off_cnt_reg == $past(cfg.offset))
    else $error("offset count not started from pulse");

  bfn_out_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    status_out[BFN_LSB +: 12] == $past(bfn_reg))
    else $error("radio frame number not on bus");

  x_out_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    status_out[X_LSB +: 8] == $past(x_reg))
    else $error("basic frame index not on bus");

endmodule

// *** verilog/aux_tx_mask_check.sv ***
// aux_tx_mask_check: flags mask bits left high while the comma is inserted
// assumes: mask arrives from logic on the same clock
`timescale 1ns/1ps
module aux_tx_mask_check
  import aux_tx_pkg::*;
#(
  parameter int MASK_W = 32
) (
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  input  wire logic [MASK_W-1:0] mask_in,
  input  wire logic              comma_slot_in,
  output logic                   error_out
);

  initial begin
    if (MASK_W < 1) $error("mask width must be positive");
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      error_out <= 1'b0;
    end else begin
      error_out <= comma_slot_in && (|mask_in);
    end
  end

  mask_flag_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (comma_slot_in && |mask_in) |=> error_out)
    else $error("mask misuse at comma not flagged");

endmodule

// *** verilog/aux_tx_pkg.sv ***
// aux_tx_pkg: constants, modes and carriers for the aux transmit status block
// assumes: one core clock domain, software reaches settings over axi4-lite
package aux_tx_pkg;

  // ****************************************
  // status bus layout
  // ****************************************
  localparam int STAT_W      = 44;
  localparam int ERR_BIT     = 43;
  localparam int SEQ_LSB     = 37;
  localparam int K_LSB       = 31;
  localparam int X_LSB       = 23;
  localparam int HFN_LSB     = 15;
  localparam int BFN_LSB     = 3;
  localparam int HFP_BIT     = 2;
  localparam int START_BIT   = 1;
  localparam int RFP_BIT     = 0;

  // ****************************************
  // frame geometry
  // ****************************************
  localparam logic [7:0]  X_LAST     = 8'hFF;
  localparam logic [7:0]  HFN_LAST   = 8'h95;
  localparam logic [5:0]  SEQ_LAST_0 = 6'h07;
  localparam logic [5:0]  SEQ_LAST_1 = 6'h0F;
  localparam logic [5:0]  SEQ_LAST_2 = 6'h13;
  localparam logic [5:0]  SEQ_LAST_3 = 6'h1F;
  localparam logic [5:0]  SEQ_LAST_4 = 6'h27;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0]  CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  OFFSET_ADDR = 8'h04;
  localparam logic [7:0]  KCFG_ADDR   = 8'h08;
  localparam logic [7:0]  STAT_ADDR   = 8'h0C;
  localparam logic [7:0]  POS_ADDR    = 8'h10;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          RATE_LSB    = 0;
  localparam int          MAP_LSB     = 4;
  localparam int          SEL_HFP_BIT = 8;
  localparam int          EN_BIT      = 12;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_1000;
  localparam logic [31:0] OFFS_RESET  = 32'h0000_0000;
  localparam logic [5:0]  KMAX_RESET  = 6'h0F;

  typedef enum logic [2:0] {
    RATE_1228, RATE_2457, RATE_3072, RATE_4195, RATE_6144
  } line_rate_t;

  typedef enum logic [1:0] {
    MAP_NONE, MAP_MODE_A, MAP_MODE_B, MAP_RSVD
  } map_mode_t;

  typedef struct packed {
    logic        error;
    logic [5:0]  seq;
    logic [5:0]  k;
    logic [7:0]  x;
    logic [7:0]  hfn;
    logic [11:0] bfn;
    logic        hfp;
    logic        start;
    logic        rfp;
  } tx_status_t;

  typedef struct packed {
    line_rate_t  rate;
    map_mode_t   map_mode;
    logic        sel_hfp;
    logic        enable;
    logic [19:0] offset;
    logic [5:0]  k_last;
  } tx_cfg_t;

  function automatic logic [5:0] seq_last(input line_rate_t r);
    case (r)
      RATE_1228: seq_last = SEQ_LAST_0;
      RATE_2457: seq_last = SEQ_LAST_1;
      RATE_3072: seq_last = SEQ_LAST_2;
      RATE_4195: seq_last = SEQ_LAST_3;
      RATE_6144: seq_last = SEQ_LAST_4;
      default:   seq_last = SEQ_LAST_0;
    endcase
  endfunction

endpackage

// *** verilog/aux_tx_regs.sv ***
// aux_tx_regs: axi4-lite slave holding the settings of the transmit status block
// assumes: master keeps one write and one read in flight at most
`timescale 1ns/1ps
module aux_tx_regs
  import aux_tx_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  input  wire tx_status_t  status_in,
  output tx_cfg_t          cfg_out
);

  logic [31:0] ctrl_reg;
  logic [31:0] offs_reg;
  logic [31:0] kcfg_reg;
  logic [7:0]  waddr_reg;
  logic        have_aw_reg;
  logic        have_w_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  // ****************************************
  // write channel
  // ****************************************
  // ready flags are flops: low from their handshake until the response is taken
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      awready_out <= 1'b1;
      wready_out  <= 1'b1;
      have_aw_reg <= 1'b0;
      have_w_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_out  <= 1'b0;
      bresp_out   <= RESP_OKAY;
      ctrl_reg    <= CTRL_RESET;
      offs_reg    <= OFFS_RESET;
      kcfg_reg    <= {26'h0, KMAX_RESET};
    end else begin
      if (awvalid_in && awready_out) begin
        awready_out <= 1'b0;
        have_aw_reg <= 1'b1;
        waddr_reg   <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        wready_out <= 1'b0;
        have_w_reg <= 1'b1;
        wdata_reg  <= wdata_in;
        wstrb_reg  <= wstrb_in;
      end
      if (have_aw_reg && have_w_reg) begin
        have_aw_reg <= 1'b0;
        have_w_reg  <= 1'b0;
        bvalid_out  <= 1'b1;
        bresp_out   <= RESP_OKAY;
        case (waddr_reg)
          CTRL_ADDR:   ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
          OFFSET_ADDR: offs_reg <= merge(offs_reg, wdata_reg, wstrb_reg);
          KCFG_ADDR:   kcfg_reg <= merge(kcfg_reg, wdata_reg, wstrb_reg);
          STAT_ADDR, POS_ADDR: bresp_out <= RESP_OKAY;
          default:     bresp_out <= RESP_SLVERR;
        endcase
      end else if (bvalid_out && bready_in) begin
        bvalid_out  <= 1'b0;
        awready_out <= 1'b1;
        wready_out  <= 1'b1;
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out  <= 32'h0000_0000;
      rresp_out  <= RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rresp_out  <= RESP_OKAY;
      case (araddr_in)
        CTRL_ADDR:   rdata_out <= ctrl_reg;
        OFFSET_ADDR: rdata_out <= offs_reg;
        KCFG_ADDR:   rdata_out <= kcfg_reg;
        STAT_ADDR:   rdata_out <= {12'h000, status_in.bfn, status_in.hfn};
        POS_ADDR:    rdata_out <= {11'h000, status_in.error, status_in.seq,
                                   status_in.k, status_in.x};
        default: begin
          rdata_out <= 32'h0000_0000;
          rresp_out <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_out && rready_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
    end
  end

  always_comb begin
    cfg_out.rate     = line_rate_t'(ctrl_reg[RATE_LSB +: 3]);
    cfg_out.map_mode = map_mode_t'(ctrl_reg[MAP_LSB +: 2]);
    cfg_out.sel_hfp  = ctrl_reg[SEL_HFP_BIT];
    cfg_out.enable   = ctrl_reg[EN_BIT];
    cfg_out.offset   = offs_reg[19:0];
    cfg_out.k_last   = kcfg_reg[5:0];
  end

endmodule
